// ---- src/watchdog_and_reset_control.sv ----
// Watchdog timer with key-coded reset control and low-voltage reset filtering
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module watchdog_and_reset_control #(
   parameter int SRESET_CYCLES = dog_reset_pkg::SRESET_CYCLES,
   parameter int SYS_RESET_CYCLES = dog_reset_pkg::SYS_RESET_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Oscillator and supply monitor pins
   input wire logic slow_internal_osc,
   input wire logic supply_low,
   // Core events
   input wire logic clear_dog_instr,
   input wire logic halt_instr,
   input wire logic low_power_mode,
   // Reset and threshold level outputs
   output logic device_reset,
   output logic pc_sp_reset,
   output logic [2:0] threshold_level
);
   // ****************************************
   // Parameter checks
   // ****************************************
   initial begin
      if (SRESET_CYCLES < 1 || SYS_RESET_CYCLES < 1) begin
         $error("Reset cycle counts must be at least one");
      end
   end

   // ****************************************
   // Declarations
   // ****************************************
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,   // Normal operation
      ST_WAIT = 3'b010,  // Software reset delay running
      ST_RESET = 3'b100  // Device reset pulse
   } rst_state_type;

   rst_state_type state_r;
   logic [7:0] dog_control_r;       // Key and timeout select
   logic [7:0] reset_key_r;         // Reset key register
   logic [7:0] threshold_r;         // Brownout threshold
   logic [1:0] lv_width_r;          // Minimum low width select
   logic dog_sw_flag_r;
   logic lv_sw_flag_r;
   logic low_v_flag_r;
   logic rst_sw_flag_r;
   logic expiry_r;                  // Expiry flag
   logic pdf_r;                     // Power down flag
   logic [1:0] osc_sync_r;          // Oscillator synchroniser
   logic [1:0] low_sync_r;          // Supply low synchroniser
   logic osc_prev_r;
   logic [17:0] dog_count_r;
   logic [7:0] lv_count_r;
   logic [31:0] delay_r;            // Delay and pulse counter
   logic [7:0] rdata_r;
   logic osc_tick;
   logic key_bad;
   logic rkey_bad;
   logic thr_bad;
   logic dog_run;
   logic overflow;
   logic brownout;
   logic sw_fault;
   logic wr_dog;

   // ****************************************
   // Decode functions
   // ****************************************
   // Top bit index of the watchdog divide
   function automatic logic [4:0] div_top(input logic [2:0] sel);
      unique case (sel)
         3'h0: div_top = 5'h07;
         3'h1: div_top = 5'h09;
         3'h2: div_top = 5'h0B;
         3'h3: div_top = 5'h0D;
         3'h4: div_top = 5'h0E;
         3'h5: div_top = 5'h0F;
         3'h6: div_top = 5'h10;
         3'h7: div_top = 5'h11;
      endcase
   endfunction

   // Minimum low-supply periods minus one
   function automatic logic [7:0] lv_limit(input logic [1:0] sel);
      unique case (sel)
         2'h0: lv_limit = 8'h07;
         2'h1: lv_limit = 8'h1F;
         2'h2: lv_limit = 8'h3F;
         2'h3: lv_limit = 8'h7F;
      endcase
   endfunction

   // True when a threshold code is one of the four defined
   function automatic logic thr_valid(input logic [7:0] v);
      thr_valid = (v == dog_reset_pkg::THR_2V10) || (v == dog_reset_pkg::THR_2V55) ||
                  (v == dog_reset_pkg::THR_3V15) || (v == dog_reset_pkg::THR_3V80);
   endfunction

   // ****************************************
   // Combinational decode
   // ****************************************
   // key decode
   assign key_bad = (dog_control_r[7:dog_reset_pkg::KEY_LSB] != dog_reset_pkg::KEY_ENABLE) &&
                    (dog_control_r[7:dog_reset_pkg::KEY_LSB] != dog_reset_pkg::KEY_DISABLE);
   assign dog_run = (dog_control_r[7:dog_reset_pkg::KEY_LSB] == dog_reset_pkg::KEY_ENABLE);
   assign rkey_bad = (reset_key_r != dog_reset_pkg::RESET_KEY_RST) &&
                     (reset_key_r != dog_reset_pkg::RESET_KEY_ALT);
   assign thr_bad = !thr_valid(threshold_r);
   assign sw_fault = key_bad || rkey_bad || thr_bad;
   assign osc_tick = osc_sync_r[1] && !osc_prev_r;
   // overflow at the selected power of two
   assign overflow = osc_tick && dog_run && (dog_count_r == 18'((1 << (div_top(dog_control_r[2:0]) + 1)) - 1));
   // brownout once low exceeds the width; not in low power
   assign brownout = osc_tick && low_sync_r[1] && !low_power_mode && (lv_count_r == lv_limit(lv_width_r));
   assign wr_dog = reg_write && (reg_addr == dog_reset_pkg::OFF_DOG_CONTROL);

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Two flops on each pin, then an edge register on the oscillator
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         osc_sync_r <= 2'h0;
         low_sync_r <= 2'h0;
         osc_prev_r <= 1'b0;
      end else begin
         osc_sync_r <= {osc_sync_r[0], slow_internal_osc};
         low_sync_r <= {low_sync_r[0], supply_low};
         osc_prev_r <= osc_sync_r[1];
      end
   end

   // ****************************************
   // Watchdog counter
   // ****************************************
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dog_count_r <= 18'h0;
      end else if (state_r == ST_RESET || clear_dog_instr || halt_instr || overflow || !dog_run) begin
         // clear on instruction, halt, overflow, any key other than enable, or reset
         dog_count_r <= 18'h0;
      end else if (osc_tick) begin
         dog_count_r <= dog_count_r + 18'h1;
      end
   end

   // ****************************************
   // Low-supply width filter
   // ****************************************
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         lv_count_r <= 8'h0;
      end else if (!low_sync_r[1] || low_power_mode || brownout) begin
         lv_count_r <= 8'h0;
      end else if (osc_tick) begin
         lv_count_r <= lv_count_r + 8'h1;
      end
   end

   // ****************************************
   // Reset sequencer
   // ****************************************
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_RUN;
         delay_r <= 32'h0;
      end else begin
         unique case (state_r)
            ST_RUN: begin
               if (brownout || (overflow && !low_power_mode)) begin
                  // normal overflow and brownout reset at once
                  state_r <= ST_RESET;
                  delay_r <= 32'h0;
               end else if (sw_fault) begin
                  state_r <= ST_WAIT;
                  delay_r <= 32'h0;
               end
            end
            ST_WAIT: begin
               if (delay_r == 32'(SRESET_CYCLES - 1)) begin
                  state_r <= ST_RESET;
                  delay_r <= 32'h0;
               end else begin
                  delay_r <= delay_r + 32'h1;
               end
            end
            ST_RESET: begin
               if (delay_r == 32'(SYS_RESET_CYCLES - 1)) begin
                  state_r <= ST_RUN;
                  delay_r <= 32'h0;
               end else begin
                  delay_r <= delay_r + 32'h1;
               end
            end
            default: begin
               state_r <= ST_RUN;
               delay_r <= 32'h0;
            end
         endcase
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dog_control_r <= dog_reset_pkg::DOG_CONTROL_RST;
         reset_key_r <= dog_reset_pkg::RESET_KEY_RST;
         threshold_r <= dog_reset_pkg::THR_2V10;
         lv_width_r <= dog_reset_pkg::LV_WIDTH_RST;
      end else if (state_r == ST_RESET && delay_r == 32'h0) begin
         // Device reset reloads keys; keeps a valid threshold
         dog_control_r <= dog_reset_pkg::DOG_CONTROL_RST;
         reset_key_r <= dog_reset_pkg::RESET_KEY_RST;
         lv_width_r <= dog_reset_pkg::LV_WIDTH_RST;
         if (thr_bad) begin
            threshold_r <= dog_reset_pkg::THR_2V10;
         end
      end else if (reg_write) begin
         unique case (reg_addr)
            dog_reset_pkg::OFF_DOG_CONTROL: dog_control_r <= reg_wdata;
            dog_reset_pkg::OFF_RESET_KEY: reset_key_r <= reg_wdata;
            dog_reset_pkg::OFF_THRESHOLD: threshold_r <= reg_wdata;
            dog_reset_pkg::OFF_LV_WIDTH: lv_width_r <= reg_wdata[1:0];
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // Reset cause flags
   // ****************************************
   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dog_sw_flag_r <= 1'b0;
         lv_sw_flag_r <= 1'b0;
         low_v_flag_r <= 1'b0;
         rst_sw_flag_r <= 1'b0;
      end else begin
         if (reg_write && reg_addr == dog_reset_pkg::OFF_RESET_FLAGS) begin
            dog_sw_flag_r <= dog_sw_flag_r & reg_wdata[dog_reset_pkg::FLAG_DOG_SW];
            lv_sw_flag_r <= lv_sw_flag_r & reg_wdata[dog_reset_pkg::FLAG_LV_SW];
            low_v_flag_r <= low_v_flag_r & reg_wdata[dog_reset_pkg::FLAG_LOW_V];
            rst_sw_flag_r <= rst_sw_flag_r & reg_wdata[dog_reset_pkg::FLAG_RST_SW];
         end
         if (state_r == ST_WAIT && delay_r == 32'(SRESET_CYCLES - 1)) begin
            // dog flag on bad enable key
            if (key_bad) dog_sw_flag_r <= 1'b1;
            // reset flag on bad reset key
            if (rkey_bad) rst_sw_flag_r <= 1'b1;
            if (thr_bad) lv_sw_flag_r <= 1'b1;
         end
         if (brownout) begin
            low_v_flag_r <= 1'b1;
         end
      end
   end

   // ****************************************
   // Status: expiry and power down
   // ****************************************
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         expiry_r <= 1'b0;
         pdf_r <= 1'b0;
      end else if (overflow) begin
         expiry_r <= 1'b1;
         pdf_r <= pdf_r | low_power_mode;
      end else if (halt_instr) begin
         pdf_r <= 1'b1;
         expiry_r <= 1'b0;
      end else if (clear_dog_instr) begin
         pdf_r <= 1'b0;
         expiry_r <= 1'b0;
      end
   end

   // ****************************************
   // Reset outputs
   // ****************************************
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         device_reset <= 1'b1;
         pc_sp_reset <= 1'b1;
      end else begin
         device_reset <= (state_r == ST_RESET);
         // sleep overflow resets PC and SP only
         pc_sp_reset <= (state_r == ST_RESET) || (overflow && low_power_mode);
      end
   end

   // threshold decode to a level index
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         threshold_level <= 3'h0;
      end else begin
         unique case (threshold_r)
            dog_reset_pkg::THR_2V10: threshold_level <= 3'h0;
            dog_reset_pkg::THR_2V55: threshold_level <= 3'h1;
            dog_reset_pkg::THR_3V15: threshold_level <= 3'h2;
            dog_reset_pkg::THR_3V80: threshold_level <= 3'h3;
            default: threshold_level <= 3'h4;
         endcase
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= 8'h0;
      end else if (reg_read) begin
         unique case (reg_addr)
            dog_reset_pkg::OFF_DOG_CONTROL: rdata_r <= dog_control_r;
            dog_reset_pkg::OFF_RESET_FLAGS: rdata_r <= {4'h0, rst_sw_flag_r, low_v_flag_r,
                                                        lv_sw_flag_r, dog_sw_flag_r};
            dog_reset_pkg::OFF_RESET_KEY: rdata_r <= reset_key_r;
            dog_reset_pkg::OFF_THRESHOLD: rdata_r <= threshold_r;
            dog_reset_pkg::OFF_LV_WIDTH: rdata_r <= {6'h0, lv_width_r};
            dog_reset_pkg::OFF_STATUS: rdata_r <= {6'h0, expiry_r, pdf_r};
            default: rdata_r <= 8'h0;
         endcase
      end else begin
         rdata_r <= 8'h0;
      end
   end
   assign reg_rdata = rdata_r;
endmodule
`default_nettype wire

// ---- src/dog_reset_pkg.sv ----
// Package: register map, field layout, reset values and timing for the watchdog and reset control
package dog_reset_pkg;
   // ****************************************
   // Register offsets (plain port index)
   // ****************************************
   localparam logic [2:0] OFF_DOG_CONTROL = 3'h0;
   localparam logic [2:0] OFF_RESET_FLAGS = 3'h1;
   localparam logic [2:0] OFF_RESET_KEY = 3'h2;
   localparam logic [2:0] OFF_THRESHOLD = 3'h3;
   localparam logic [2:0] OFF_LV_WIDTH = 3'h4;
   localparam logic [2:0] OFF_STATUS = 3'h5;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int KEY_LSB = 3;
   localparam int FLAG_DOG_SW = 0;
   localparam int FLAG_LV_SW = 1;
   localparam int FLAG_LOW_V = 2;
   localparam int FLAG_RST_SW = 3;
   localparam int STAT_PDF = 0;
   localparam int STAT_EXPIRY = 1;
   // ****************************************
   // Reset values and keys
   // ****************************************
   localparam logic [7:0] DOG_CONTROL_RST = 8'h53;
   localparam logic [4:0] KEY_ENABLE = 5'h0A;
   localparam logic [4:0] KEY_DISABLE = 5'h15;
   localparam logic [7:0] RESET_KEY_RST = 8'h55;
   localparam logic [7:0] RESET_KEY_ALT = 8'hAA;
   localparam logic [7:0] THR_2V10 = 8'h55;
   localparam logic [7:0] THR_2V55 = 8'h33;
   localparam logic [7:0] THR_3V15 = 8'h99;
   localparam logic [7:0] THR_3V80 = 8'hAA;
   localparam logic [1:0] LV_WIDTH_RST = 2'h1;
   // ****************************************
   // Timing
   // ****************************************
   localparam int OSC_HZ = 32000;
   localparam int CLK_HZ = 200000000;
   localparam int SRESET_US = 100;
   localparam int SRESET_CYCLES = (SRESET_US * (CLK_HZ / 1000000));
   localparam int SYS_RESET_CYCLES = 16;
endpackage

// ---- bench/watchdog_and_reset_control_checker.sv ----
// Checker: port assertions for the watchdog and reset control block
`timescale 1ns/10ps
`default_nettype none
module watchdog_and_reset_control_checker #(
   parameter int SRESET_CYCLES = 4,
   parameter int SYS_RESET_CYCLES = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // Reset and threshold level outputs
   input wire logic device_reset,
   input wire logic pc_sp_reset,
   input wire logic [2:0] threshold_level
);
   // ****************************************
   // Helpers
   // ****************************************
   localparam int RST_MAX = SRESET_CYCLES + 12;
   logic [7:0] hi_cnt_r; // Length of the running reset pulse
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // Counts cycles of device reset
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         hi_cnt_r <= 8'h00;
      end else begin
         hi_cnt_r <= device_reset ? hi_cnt_r + 8'h01 : 8'h00;
      end
   end
   // Level code for a threshold byte
   function automatic logic [2:0] lvl(input logic [7:0] v);
      case (v)
         8'h55: return 3'h0;
         8'h33: return 3'h1;
         8'h99: return 3'h2;
         8'hAA: return 3'h3;
         default: return 3'h4;
      endcase
   endfunction
   // A bad key or threshold write taken while running
   sequence s_bad_write(logic [2:0] a, logic bad);
      reg_write && !device_reset && reg_addr == a && bad;
   endsequence
   // Delayed software reset
   sequence s_soft_reset;
      (!device_reset)[*3] ##[1:RST_MAX] device_reset;
   endsequence
   // ****************************************
   // Assertions
   // ****************************************
   AST_RSTKEY_BAD: assert property (s_bad_write(3'h2, !(reg_wdata inside {8'h55, 8'hAA})) |=> s_soft_reset)
      else $error("bad reset key gave no delayed reset");
   AST_DOGKEY_BAD: assert property (s_bad_write(3'h0, !(reg_wdata[7:3] inside {5'h0A, 5'h15})) |=> s_soft_reset)
      else $error("bad enable key gave no delayed reset");
   AST_THR_BAD: assert property (s_bad_write(3'h3, lvl(reg_wdata) == 3'h4) |=> s_soft_reset)
      else $error("bad threshold gave no delayed reset");
   AST_THR_LEVEL: assert property ($past(reg_read && reg_addr == 3'h3) |-> threshold_level == lvl(reg_rdata))
      else $error("threshold level does not match register");
   AST_FLAG_HIGH_ZERO: assert property ($past(reg_read) && $past(reg_addr) == 3'h1 |-> reg_rdata[7:4] == 4'h0)
      else $error("flag register upper bits not zero");
   AST_UNMAPPED_READ: assert property (reg_read && reg_addr > 3'h5 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_PCSP_WITH_RESET: assert property (device_reset |-> pc_sp_reset)
      else $error("device reset without pc and sp reset");
   AST_SLEEP_PULSE: assert property (pc_sp_reset && !device_reset |=> !pc_sp_reset && !device_reset)
      else $error("sleep overflow pulse too long or reset device");
   AST_RESET_LEN: assert property ($fell(device_reset) && hi_cnt_r > 8'h01 |-> hi_cnt_r == SYS_RESET_CYCLES)
      else $error("device reset pulse length wrong");
endmodule
bind watchdog_and_reset_control watchdog_and_reset_control_checker #(.SRESET_CYCLES(SRESET_CYCLES),
   .SYS_RESET_CYCLES(SYS_RESET_CYCLES)) u_watchdog_and_reset_control_checker (.clk_sys(clk_sys),
   .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .device_reset(device_reset), .pc_sp_reset(pc_sp_reset), .threshold_level(threshold_level));
`default_nettype wire

// ---- bench/watchdog_and_reset_control_tb.sv ----
// Testbench: directed scenarios for the watchdog and reset control block
`timescale 1ns/10ps
`default_nettype none
module watchdog_and_reset_control_tb;
   // ****************************************
   // Signals
   // ****************************************
   localparam int SRST = 4; // Short software reset delay
   logic clk_sys, reset_n, reg_write, reg_read, slow_internal_osc, supply_low;
   logic clear_dog_instr, halt_instr, low_power_mode, device_reset, pc_sp_reset;
   logic [2:0] reg_addr, threshold_level;
   logic [7:0] reg_wdata, reg_rdata, d;
   logic [1:0] osc_div; // Oscillator divider, period 8 clocks
   int n_fail = 0;
   int check_count = 0;
   int n;
   `define CHK(g, e) begin #1; check_count++; if ((g) !== (e)) begin n_fail++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
   watchdog_and_reset_control #(.SRESET_CYCLES(SRST), .SYS_RESET_CYCLES(16)) u_watchdog_and_reset_control (
      .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .slow_internal_osc(slow_internal_osc), .supply_low(supply_low),
      .clear_dog_instr(clear_dog_instr), .halt_instr(halt_instr), .low_power_mode(low_power_mode),
      .device_reset(device_reset), .pc_sp_reset(pc_sp_reset), .threshold_level(threshold_level));
   // System clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Slow oscillator, free running
   always @(posedge clk_sys) begin
      osc_div <= osc_div + 2'h1;
      if (osc_div == 2'h3) begin
         slow_internal_osc <= ~slow_internal_osc;
      end
   end
   // ****************************************
   // Bus and helper tasks
   // ****************************************
   task wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask
   task rd(input logic [2:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task rchk(input logic [2:0] a, input logic [7:0] e);
      rd(a);
      `CHK(d, e)
   endtask
   // One-cycle clear (0) or halt (1) pulse
   task pulse(input bit h);
      @(posedge clk_sys);
      if (h) halt_instr <= 1'b1;
      else clear_dog_instr <= 1'b1;
      @(posedge clk_sys);
      halt_instr <= 1'b0;
      clear_dog_instr <= 1'b0;
   endtask
   // Cycles until a reset output rises; a device reset is then waited out
   task wait_out(input int lim, input bit sleep);
      n = 0;
      while ((sleep ? pc_sp_reset : device_reset) !== 1'b1 && n < lim) begin
         @(posedge clk_sys);
         #1 n++;
      end
      if (!sleep) repeat (30) @(posedge clk_sys);
   endtask
   // Counts reset activity over a window
   task quiet(input int cyc);
      n = 0;
      repeat (cyc) begin
         @(posedge clk_sys);
         #1 if (device_reset !== 1'b0 || pc_sp_reset !== 1'b0) n++;
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task t_regs;
      rchk(3'h0, 8'h53);
      rd(3'h1);
      `CHK(d & 8'hFB, 8'h00)
      rchk(3'h2, 8'h55);
      rchk(3'h3, 8'h55);
      rchk(3'h4, 8'h01);
      rchk(3'h5, 8'h00);
      wr(3'h7, 8'hFF);
      rchk(3'h7, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_codes;
      logic [7:0] c[4] = '{8'h55, 8'h33, 8'h99, 8'hAA};
      for (int i = 0; i < 4; i++) begin
         wr(3'h3, c[i]);
         rchk(3'h3, c[i]);
         `CHK(threshold_level, 3'(i))
      end
      wr(3'h2, 8'hAA);
      wr(3'h2, 8'h55);
      quiet(40);
      `CHK(n, 0)
      $display("t_codes done");
   endtask
   task automatic t_soft;
      logic [2:0] a[3] = '{3'h2, 3'h0, 3'h3};
      logic [7:0] v[3] = '{8'h00, 8'h03, 8'h12};
      logic [7:0] r[3] = '{8'h55, 8'h53, 8'h55};
      logic [7:0] f[3] = '{8'h08, 8'h01, 8'h02};
      for (int i = 0; i < 3; i++) begin
         wr(a[i], v[i]);
         wait_out(60, 1'b0);
         `CHK(n >= SRST && n < 30, 1'b1)
         rd(3'h1);
         `CHK(d & 8'hFB, f[i])
         rchk(a[i], r[i]);
         wr(3'h1, 8'h00);
         rd(3'h1);
         `CHK(d & 8'hFB, 8'h00)
      end
      $display("t_soft done");
   endtask
   task t_dog;
      for (int i = 0; i < 2; i++) begin
         pulse(1'b0);
         wr(3'h0, {5'h0A, 3'(i)});
         quiet(1024 << (2 * i));
         `CHK(n, 0)
         pulse(1'b0);
         wait_out((2048 << (2 * i)) + 64, 1'b0);
         `CHK(n > (2048 << (2 * i)) - 24 && n < (2048 << (2 * i)) + 40, 1'b1)
         rd(3'h5);
         `CHK(d[1], 1'b1)
      end
      $display("t_dog done");
   endtask
   task t_sleep;
      @(posedge clk_sys);
      low_power_mode <= 1'b1;
      pulse(1'b0);
      wr(3'h0, 8'h50);
      pulse(1'b1);
      wait_out(2200, 1'b1);
      `CHK({n < 2200, device_reset}, 2'b10)
      rd(3'h5);
      `CHK(d, 8'h03)
      pulse(1'b0);
      rd(3'h5);
      `CHK(d, 8'h00)
      wr(3'h0, 8'hAB);
      quiet(2400);
      `CHK(n, 0)
      $display("t_sleep done");
   endtask
   task t_brown;
      wr(3'h4, 8'h00);
      wr(3'h3, 8'h33);
      @(posedge clk_sys);
      supply_low <= 1'b1;
      quiet(200);
      `CHK(n, 0)
      @(posedge clk_sys);
      supply_low <= 1'b0;
      low_power_mode <= 1'b0;
      quiet(20);
      @(posedge clk_sys);
      supply_low <= 1'b1;
      quiet(40);
      @(posedge clk_sys);
      supply_low <= 1'b0;
      `CHK(n, 0)
      quiet(20);
      @(posedge clk_sys);
      supply_low <= 1'b1;
      wait_out(200, 1'b0);
      `CHK(n > 56 && n < 100, 1'b1)
      @(posedge clk_sys);
      supply_low <= 1'b0;
      rd(3'h1);
      `CHK(d[2], 1'b1)
      rchk(3'h3, 8'h33);
      rchk(3'h4, 8'h01);
      wr(3'h1, 8'h00);
      rd(3'h1);
      `CHK(d[2], 1'b0)
      $display("t_brown done");
   endtask
   // Prints the verdict and stops
   task end_sim;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      reset_n = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      slow_internal_osc = 1'b0;
      osc_div = 2'h0;
      supply_low = 1'b0;
      clear_dog_instr = 1'b0;
      halt_instr = 1'b0;
      low_power_mode = 1'b0;
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      `CHK({device_reset, pc_sp_reset}, 2'b11)
      t_regs;
      t_codes;
      t_soft;
      t_dog;
      t_sleep;
      t_brown;
      end_sim;
   end
   // Hang guard
   initial begin
      repeat (60000) @(posedge clk_sys);
      n_fail++;
      end_sim;
   end
endmodule
`default_nettype wire
